//--- hw/rpmrx_pkg.sv
`default_nettype none
package rpmrx_pkg;
	// ==========================================================
	// phy control register layout
	localparam int unsigned SUBMODE_BIT   = 2;
	localparam int unsigned MODSEL_BIT    = 3;
	localparam int unsigned ALTSPEC_BIT   = 4;
	localparam int unsigned SCRAM_BIT     = 5;
	localparam int unsigned SAFE_BIT      = 7;
	localparam int unsigned RATE_LSB      = 0;
	localparam logic [7:0]  PHY_CTRL_RST  = 8'h20;
	// ==========================================================
	// symbol periods in ns and derived cycle counts at 200 MHz
	localparam int unsigned CLK_NS        = 5;
	localparam int unsigned SYM_BPSK20_NS = 50000;
	localparam int unsigned SYM_BPSK40_NS = 25000;
	localparam int unsigned SYM_QLOW_NS   = 40000;
	localparam int unsigned SYM_QHIGH_NS  = 16000;
	localparam logic [15:0] SYM_BPSK20    = 16'((SYM_BPSK20_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] SYM_BPSK40    = 16'((SYM_BPSK40_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] SYM_QLOW      = 16'((SYM_QLOW_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] SYM_QHIGH     = 16'((SYM_QHIGH_NS + CLK_NS - 1) / CLK_NS);
	// ==========================================================
	// timing in symbol periods
	localparam logic [3:0]  ACK_STD_SYM   = 4'hc;
	localparam logic [3:0]  ACK_LOW_SYM   = 4'h2;
	localparam logic [3:0]  ACK_HIGH_SYM  = 4'h3;
	localparam logic [3:0]  ED_AUTO_SYM   = 4'h2;
	localparam logic [3:0]  ED_STD_SYM    = 4'h8;
	// ==========================================================
	// state commands and status codes
	localparam logic [4:0]  CMD_NOP       = 5'h00;
	localparam logic [4:0]  CMD_RX_ON     = 5'h06;
	localparam logic [4:0]  CMD_TRANSCEIVER_OFF_STATE   = 5'h08;
	localparam logic [4:0]  CMD_PLL_ON    = 5'h09;
	localparam logic [4:0]  CMD_AACK_ON   = 5'h16;
	localparam logic [4:0]  ST_OFF        = 5'h08;
	localparam logic [4:0]  ST_PLL        = 5'h09;
	localparam logic [4:0]  ST_RX         = 5'h06;
	localparam logic [4:0]  ST_BUSY       = 5'h01;
	localparam logic [4:0]  ST_AACK       = 5'h16;
	localparam logic [4:0]  ST_AACK_BUSY  = 5'h11;
	// ==========================================================
	// host apb register offsets
	localparam logic [7:0]  A_PHY_CTRL    = 8'h00;
	localparam logic [7:0]  A_SYNC        = 8'h04;
	localparam logic [7:0]  A_EXT         = 8'h08;
	localparam logic [7:0]  A_CMD         = 8'h0c;
	localparam logic [7:0]  A_STATUS      = 8'h10;
	localparam logic [7:0]  A_TIMING      = 8'h14;
	localparam logic [7:0]  A_RXINFO      = 8'h18;
	localparam logic [7:0]  A_RELEASE     = 8'h1c;
	localparam int unsigned PDT_LSB       = 0;
	localparam int unsigned PDT_DIS_BIT   = 7;
	localparam int unsigned ACKT_BIT      = 2;
	localparam int unsigned HR_BIT        = 31;
	localparam int unsigned CS_BIT        = 30;
	// high rate: qpsk with nonzero rate field
	typedef enum logic [1:0] {RPMRX_M_BPSK, RPMRX_M_QLOW, RPMRX_M_QHIGH} rpmrx_family_t;
	typedef enum logic [2:0] {
		RPMRX_OFF  = 3'b000,
		RPMRX_PLL  = 3'b001,
		RPMRX_LSN  = 3'b011,
		RPMRX_BUSY = 3'b010,
		RPMRX_HOLD = 3'b110
	} rpmrx_state_t;
endpackage : rpmrx_pkg
`default_nettype wire

//--- hw/rpmrx_if.sv
`default_nettype none
interface rpmrx_if;
	// control plane
	logic [7:0] phy_control_reg;
	logic [7:0] receiver_sync_reg;
	logic [7:0] extended_mode_control_reg;
	logic [4:0] state_command_field;
	logic       cmd_strobe;
	logic [4:0] transceiver_status_field;
	// timing and mode reports
	logic [15:0] symbol_cycles;
	logic [3:0]  ack_symbols;
	logic [3:0]  ed_auto_symbols;
	logic        high_rate;
	logic        scramble_on;
	logic        cs_cca_allowed;
	logic [2:0]  psdu_code_div;
	// frame read path
	logic        frame_select_n;
	logic [23:0] rx_info;
	logic        rx_info_valid;
	modport dev  (input phy_control_reg, receiver_sync_reg, extended_mode_control_reg, state_command_field,
		cmd_strobe, frame_select_n, output transceiver_status_field, symbol_cycles, ack_symbols,
		ed_auto_symbols, high_rate, scramble_on, cs_cca_allowed, psdu_code_div, rx_info, rx_info_valid);
	modport host (output phy_control_reg, receiver_sync_reg, extended_mode_control_reg, state_command_field,
		cmd_strobe, frame_select_n, input transceiver_status_field, symbol_cycles, ack_symbols,
		ed_auto_symbols, high_rate, scramble_on, cs_cca_allowed, psdu_code_div, rx_info, rx_info_valid);
endinterface : rpmrx_if
`default_nettype wire

//--- hw/rpmrx_mode_decode.sv
`default_nettype none
// ==========================================================
// mode decoder: family, rates, timing in symbols
module rpmrx_mode_decode (
	// configuration
	input  wire logic [7:0]  phy_ctrl,
	input  wire logic        reduced_ack_time_bit,
	// decoded
	output logic [15:0] sym_cycles,
	output logic [3:0]  ack_sym,
	output logic [3:0]  ed_sym,
	output logic        high_rate,
	output logic        scramble,
	output logic [2:0]  code_div
);
	logic [1:0] rate;
	logic       modsel;
	logic       submode;
	assign rate    = phy_ctrl[rpmrx_pkg::RATE_LSB +: 2];
	assign modsel  = phy_ctrl[rpmrx_pkg::MODSEL_BIT];
	assign submode = phy_ctrl[rpmrx_pkg::SUBMODE_BIT];
	// period depends only on base mode, never on the rate field
	always_comb
	begin
		if (!modsel)
			sym_cycles = submode ? rpmrx_pkg::SYM_BPSK40 : rpmrx_pkg::SYM_BPSK20;
		else
			sym_cycles = submode ? rpmrx_pkg::SYM_QHIGH : rpmrx_pkg::SYM_QLOW;
		high_rate = modsel && (rate != 2'h0);
		// header stays at base rate; divider applies only to psdu
		code_div  = !high_rate ? 3'h1 : ((rate == 2'h2) ? 3'h4 : 3'h2);
		scramble  = high_rate && rate[1] && !rate[0] && phy_ctrl[rpmrx_pkg::SCRAM_BIT];
		if (high_rate && reduced_ack_time_bit)
			ack_sym = submode ? rpmrx_pkg::ACK_HIGH_SYM : rpmrx_pkg::ACK_LOW_SYM;
		else
			ack_sym = rpmrx_pkg::ACK_STD_SYM;
		ed_sym = high_rate ? rpmrx_pkg::ED_AUTO_SYM : rpmrx_pkg::ED_STD_SYM;
	end
endmodule : rpmrx_mode_decode
`default_nettype wire

//--- hw/rpmrx_device.sv
// Added by the designer: the APB register port and the register addresses.
`default_nettype none
// Operation
// - mode chosen from phy control bits
// - host goes off before mode change
// - bpsk symbol periods 50 and 25 us
// - qpsk symbol periods 40 and 16 us
// - high rate uses base symbol period
// - low chip rate gives 200/400 kb/s
// - high chip rate gives 500/1000 kb/s
// - header at base rate, psdu fast
// - reduced ack two or three symbols
// - standard ack twelve symbols
// - weak frames below threshold ignored
// - scrambling at 400/1000 unless disabled
// - auto energy detect two symbols at high rate
// - no carrier sense cca at high rate
// - host discards lqi at high rate
// - sfd moves listen to busy
// - frame end returns to listening
// - lqi ed status appended on read
// - listen command from off or pll
// - auto ack listen only from pll
// - safe mode holds until select high
// - protection only on good fcs
module rpmrx_device (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// host side
	rpmrx_if.dev            hif,
	// radio peer frame events
	input  wire logic       sfd_found,
	input  wire logic [7:0] frame_rssi,
	input  wire logic       frame_done,
	input  wire logic       fcs_ok,
	input  wire logic [7:0] frame_lqi,
	input  wire logic [7:0] frame_ed,
	// demodulator controls
	output logic            demod_enable,
	output logic            buffer_protected
);
	rpmrx_pkg::rpmrx_state_t state;
	rpmrx_pkg::rpmrx_state_t next_state;
	logic                    aack;
	logic                    next_aack;
	logic [23:0]             info;
	logic [23:0]             next_info;
	logic                    info_valid;
	logic                    next_info_valid;
	logic                    prot;
	logic                    next_prot;
	logic                    sel_seen;
	logic                    next_sel_seen;
	logic                    pdt_dis;
	logic                    sync_ok;
	logic                    go_off;
	logic                    go_pll;
	logic                    frame_end;

	// command decode shared by the state and protection groups
	function automatic logic cmd_hit(input logic stb, input logic [4:0] field, input logic [4:0] code);
		return stb && (field == code);
	endfunction : cmd_hit

	// ==========================================================
	// mode decode
	rpmrx_mode_decode rpmrx_mode_decode_inst (
		.phy_ctrl             (hif.phy_control_reg),
		.reduced_ack_time_bit (hif.extended_mode_control_reg[rpmrx_pkg::ACKT_BIT]),
		.sym_cycles           (hif.symbol_cycles),
		.ack_sym              (hif.ack_symbols),
		.ed_sym               (hif.ed_auto_symbols),
		.high_rate            (hif.high_rate),
		.scramble             (hif.scramble_on),
		.code_div             (hif.psdu_code_div)
	);
	assign hif.cs_cca_allowed = !hif.high_rate;

	// ==========================================================
	// receive state machine
	assign pdt_dis = hif.receiver_sync_reg[rpmrx_pkg::PDT_DIS_BIT];
	// unsigned compare; threshold zero lets every frame through
	assign sync_ok = sfd_found && !pdt_dis && !prot &&
		(frame_rssi >= {1'b0, hif.receiver_sync_reg[6:0]});
	// pll on is refused mid frame so it cannot cut a reception short; off still can
	assign go_off    = cmd_hit(hif.cmd_strobe, hif.state_command_field, rpmrx_pkg::CMD_TRANSCEIVER_OFF_STATE);
	assign go_pll    = cmd_hit(hif.cmd_strobe, hif.state_command_field, rpmrx_pkg::CMD_PLL_ON) &&
		(state != rpmrx_pkg::RPMRX_BUSY);
	assign frame_end = frame_done && (state == rpmrx_pkg::RPMRX_BUSY);

	// next state, command handling and frame bookkeeping
	always_comb
	begin
		next_state      = state;
		next_aack       = aack;
		next_info       = info;
		next_info_valid = info_valid;
		if (go_off)
			next_state = rpmrx_pkg::RPMRX_OFF;
		else if (go_pll)
			next_state = rpmrx_pkg::RPMRX_PLL;
		else
		begin
			case (state)
				rpmrx_pkg::RPMRX_OFF, rpmrx_pkg::RPMRX_PLL:
				begin
					if (cmd_hit(hif.cmd_strobe, hif.state_command_field, rpmrx_pkg::CMD_RX_ON))
					begin
						next_state = rpmrx_pkg::RPMRX_LSN;
						next_aack  = 1'b0;
					end
					else if (cmd_hit(hif.cmd_strobe, hif.state_command_field, rpmrx_pkg::CMD_AACK_ON) &&
						state == rpmrx_pkg::RPMRX_PLL)
					begin
						next_state = rpmrx_pkg::RPMRX_LSN;
						next_aack  = 1'b1;
					end
				end
				rpmrx_pkg::RPMRX_LSN:
					if (sync_ok)
						next_state = rpmrx_pkg::RPMRX_BUSY;
				rpmrx_pkg::RPMRX_BUSY:
					if (frame_done)
					begin
						next_state      = rpmrx_pkg::RPMRX_LSN;
						next_info       = {frame_lqi, frame_ed, 7'h00, fcs_ok};
						next_info_valid = 1'b1;
					end
				default:
					next_state = rpmrx_pkg::RPMRX_OFF;
			endcase
		end
	end

	// state registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state      <= rpmrx_pkg::RPMRX_OFF;
			aack       <= 1'b0;
			info       <= 24'h000000;
			info_valid <= 1'b0;
		end
		else
		begin
			state      <= next_state;
			aack       <= next_aack;
			info       <= next_info;
			info_valid <= next_info_valid;
		end
	end

	// ==========================================================
	// dynamic buffer protection and upload tracking
	// a held frame is freed by off or pll, or once select went low and back high
	always_comb
	begin
		next_prot     = prot;
		next_sel_seen = sel_seen;
		if (go_off || go_pll)
		begin
			next_prot     = 1'b0;
			next_sel_seen = 1'b0;
		end
		else if (frame_end)
		begin
			// only a good frame is worth holding against overwrite
			next_prot     = hif.phy_control_reg[rpmrx_pkg::SAFE_BIT] && fcs_ok;
			next_sel_seen = 1'b0;
		end
		else if (prot && !hif.frame_select_n)
			next_sel_seen = 1'b1;
		else if (prot && sel_seen)
		begin
			next_prot     = 1'b0;
			next_sel_seen = 1'b0;
		end
	end

	// protection registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prot     <= 1'b0;
			sel_seen <= 1'b0;
		end
		else
		begin
			prot     <= next_prot;
			sel_seen <= next_sel_seen;
		end
	end

	// ==========================================================
	// status outputs
	always_comb
	begin
		case (state)
			rpmrx_pkg::RPMRX_OFF:  hif.transceiver_status_field = rpmrx_pkg::ST_OFF;
			rpmrx_pkg::RPMRX_PLL:  hif.transceiver_status_field = rpmrx_pkg::ST_PLL;
			rpmrx_pkg::RPMRX_LSN:  hif.transceiver_status_field = aack ? rpmrx_pkg::ST_AACK : rpmrx_pkg::ST_RX;
			rpmrx_pkg::RPMRX_BUSY: hif.transceiver_status_field = aack ? rpmrx_pkg::ST_AACK_BUSY : rpmrx_pkg::ST_BUSY;
			default:               hif.transceiver_status_field = rpmrx_pkg::ST_OFF;
		endcase
	end
	assign hif.rx_info          = info;
	assign hif.rx_info_valid    = info_valid;
	assign demod_enable         = (state == rpmrx_pkg::RPMRX_BUSY);
	assign buffer_protected     = prot;
endmodule : rpmrx_device
`default_nettype wire

//--- hw/rpmrx_host.sv
`default_nettype none
// ==========================================================
// host controller: apb registers driving the device interface
module rpmrx_host (
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// device side
	rpmrx_if.host            dif
);
	logic [7:0]  phy;
	logic [7:0]  next_phy;
	logic [7:0]  syn;
	logic [7:0]  next_syn;
	logic [7:0]  ext;
	logic [7:0]  next_ext;
	logic [4:0]  cmd;
	logic [4:0]  next_cmd;
	logic        stb;
	logic        next_stb;
	logic        seln;
	logic        next_seln;
	logic [31:0] rd;
	logic [31:0] next_rd;
	logic        acc;
	logic        off;

	assign acc = psel && penable;
	assign off = (dif.transceiver_status_field == rpmrx_pkg::ST_OFF);

	// register writes and read mux
	always_comb
	begin
		next_phy  = phy;
		next_syn  = syn;
		next_ext  = ext;
		next_cmd  = cmd;
		next_stb  = 1'b0;
		next_seln = seln;
		next_rd   = rd;
		if (acc && pwrite)
		begin
			case (paddr)
				// mode bits only change while off; otherwise ignored
				rpmrx_pkg::A_PHY_CTRL: if (off) next_phy = pwdata[7:0];
				rpmrx_pkg::A_SYNC:    next_syn = pwdata[7:0];
				rpmrx_pkg::A_EXT:     next_ext = pwdata[7:0];
				rpmrx_pkg::A_CMD:
				begin
					next_cmd = pwdata[4:0];
					next_stb = 1'b1;
				end
				rpmrx_pkg::A_RELEASE: next_seln = pwdata[0];
				default:              next_seln = seln; // writes elsewhere are dropped
			endcase
		end
		else if (psel && !penable && !pwrite) // captured at setup so prdata comes from a flop
		begin
			case (paddr)
				rpmrx_pkg::A_PHY_CTRL: next_rd = {24'h000000, phy};
				rpmrx_pkg::A_SYNC:     next_rd = {24'h000000, syn};
				rpmrx_pkg::A_EXT:      next_rd = {24'h000000, ext};
				rpmrx_pkg::A_CMD:      next_rd = {27'h0000000, cmd};
				rpmrx_pkg::A_STATUS:   next_rd = {27'h0000000, dif.transceiver_status_field};
				rpmrx_pkg::A_TIMING:   next_rd = {dif.high_rate, dif.cs_cca_allowed, 3'h0, dif.psdu_code_div,
					dif.ed_auto_symbols, dif.ack_symbols, dif.symbol_cycles};
				// lqi byte zeroed at high rate: it carries nothing useful
				rpmrx_pkg::A_RXINFO:   next_rd = {7'h00, dif.rx_info_valid,
					dif.high_rate ? 8'h00 : dif.rx_info[23:16], dif.rx_info[15:0]};
				rpmrx_pkg::A_RELEASE:  next_rd = {31'h00000000, seln};
				default:               next_rd = 32'h00000000;
			endcase
		end
	end

	// registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phy  <= rpmrx_pkg::PHY_CTRL_RST;
			syn  <= 8'h00;
			ext  <= 8'h00;
			cmd  <= rpmrx_pkg::CMD_NOP;
			stb  <= 1'b0;
			seln <= 1'b1;
			rd   <= 32'h00000000;
		end
		else
		begin
			phy  <= next_phy;
			syn  <= next_syn;
			ext  <= next_ext;
			cmd  <= next_cmd;
			stb  <= next_stb;
			seln <= next_seln;
			rd   <= next_rd;
		end
	end

	// zero wait state slave; read data registered at the end of the setup cycle
	assign pready  = 1'b1;
	assign pslverr = acc && (paddr[1:0] != 2'h0 || (paddr > rpmrx_pkg::A_RELEASE));
	assign prdata  = rd;
	assign dif.phy_control_reg           = phy;
	assign dif.receiver_sync_reg         = syn;
	assign dif.extended_mode_control_reg = ext;
	assign dif.state_command_field       = cmd;
	assign dif.cmd_strobe                = stb;
	assign dif.frame_select_n            = seln;
endmodule : rpmrx_host
`default_nettype wire

//--- tb/rpmrx_checker.sv
`default_nettype none
// ==========================================================
// link checker: mode decode and state flow between the two ends
module rpmrx_checker (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// host driven
	input  wire logic [7:0]  phy_control_reg,
	input  wire logic [7:0]  extended_mode_control_reg,
	input  wire logic [4:0]  state_command_field,
	input  wire logic        cmd_strobe,
	// device driven
	input  wire logic [4:0]  transceiver_status_field,
	input  wire logic [15:0] symbol_cycles,
	input  wire logic [3:0]  ack_symbols,
	input  wire logic [3:0]  ed_auto_symbols,
	input  wire logic        high_rate,
	input  wire logic        scramble_on,
	input  wire logic        cs_cca_allowed,
	input  wire logic [2:0]  psdu_code_div
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       qpsk;
	logic       fast;
	logic [1:0] rate;
	logic [4:0] st;
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// shorthands; a nonzero rate field under qpsk is the fast family
	assign qpsk = phy_control_reg[3];
	assign rate = phy_control_reg[1:0];
	assign fast = qpsk && (rate != 2'h0);
	assign st   = transceiver_status_field;
	// ==========================================================
	// decode
	AST_SYM_PERIOD: assert property (symbol_cycles == (qpsk ? (phy_control_reg[2] ? 16'h0c80 : 16'h1f40)
		: (phy_control_reg[2] ? 16'h1388 : 16'h2710))) else $error("symbol period wrong");
	AST_HIGH_RATE: assert property (high_rate == fast) else $error("high rate flag wrong");
	AST_CODE_DIV: assert property (qpsk |->
		psdu_code_div == (rate == 2'h0 ? 3'h1 : (rate == 2'h2 ? 3'h4 : 3'h2))) else $error("code divider wrong");
	AST_ACK_TIME: assert property (ack_symbols == ((fast && extended_mode_control_reg[2])
		? (phy_control_reg[2] ? 4'h3 : 4'h2) : 4'hc)) else $error("ack time wrong");
	AST_ED_CS: assert property (ed_auto_symbols == (fast ? 4'h2 : 4'h8) && cs_cca_allowed == !fast)
		else $error("energy detect or carrier sense wrong");
	AST_SCRAM: assert property (qpsk && rate == 2'h2 |-> scramble_on == phy_control_reg[5])
		else $error("scrambler wrong");
	AST_PHY_HOLD: assert property ($changed(phy_control_reg) |-> $past(st) == rpmrx_pkg::ST_OFF)
		else $error("mode changed outside off");
	// ==========================================================
	// state flow
	AST_RX_ON: assert property (cmd_strobe && state_command_field == rpmrx_pkg::CMD_RX_ON
		&& (st == rpmrx_pkg::ST_OFF || st == rpmrx_pkg::ST_PLL) |=> st == rpmrx_pkg::ST_RX)
		else $error("listen command not obeyed");
	AST_AACK_ON: assert property (cmd_strobe && state_command_field == rpmrx_pkg::CMD_AACK_ON
		&& (st == rpmrx_pkg::ST_OFF || st == rpmrx_pkg::ST_PLL)
		|=> st == ($past(st) == rpmrx_pkg::ST_PLL ? rpmrx_pkg::ST_AACK : rpmrx_pkg::ST_OFF))
		else $error("auto ack listen start wrong");
	AST_BUSY_ENTRY: assert property ($changed(st) && st == rpmrx_pkg::ST_BUSY
		|-> $past(st) == rpmrx_pkg::ST_RX) else $error("busy entered from wrong state");
	AST_BUSY_EXIT: assert property (st == rpmrx_pkg::ST_BUSY && !cmd_strobe ##1 st != rpmrx_pkg::ST_BUSY
		|-> st == rpmrx_pkg::ST_RX) else $error("frame end did not return to listening");
	// ==========================================================
	// coverage of the main scenarios
	COV_BUSY: cover property (st == rpmrx_pkg::ST_BUSY);
	COV_AACK: cover property (st == rpmrx_pkg::ST_AACK);
	COV_FAST_ACK: cover property (fast && extended_mode_control_reg[2] && phy_control_reg[2]);
endmodule : rpmrx_checker
`default_nettype wire

//--- tb/test_radio_phy_mode_rx_control.sv
`default_nettype none
`define CHK(n, e, g) \
	begin \
		checks_done++; \
		if ((g) !== (e)) \
		begin \
			err_count++; \
			$display("Error %s expected %h seen %h", n, e, g); \
		end \
	end
module test_radio_phy_mode_rx_control;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// signals
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sfd_found;
	logic [7:0]  frame_rssi;
	logic        frame_done;
	logic        fcs_ok;
	logic [7:0]  frame_lqi;
	logic [7:0]  frame_ed;
	logic        demod_enable;
	logic        buffer_protected;
	logic [34:0] exp_q[$];
	logic [34:0] msk_q[$];
	logic [34:0] e_cur;
	logic [34:0] m_cur;
	logic [7:0]  phy;
	logic        ackb;
	integer      seed;
	int          err_count;
	int          checks_done;
	rpmrx_if bus_if ();
	rpmrx_host rpmrx_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dif(bus_if));
	rpmrx_device rpmrx_device_inst (.pclk(pclk), .presetn(presetn), .hif(bus_if), .sfd_found(sfd_found),
		.frame_rssi(frame_rssi), .frame_done(frame_done), .fcs_ok(fcs_ok), .frame_lqi(frame_lqi),
		.frame_ed(frame_ed), .demod_enable(demod_enable), .buffer_protected(buffer_protected));
	rpmrx_checker rpmrx_checker_inst (.pclk(pclk), .presetn(presetn), .phy_control_reg(bus_if.phy_control_reg),
		.extended_mode_control_reg(bus_if.extended_mode_control_reg), .cmd_strobe(bus_if.cmd_strobe),
		.state_command_field(bus_if.state_command_field), .transceiver_status_field(bus_if.transceiver_status_field),
		.symbol_cycles(bus_if.symbol_cycles), .ack_symbols(bus_if.ack_symbols), .high_rate(bus_if.high_rate),
		.ed_auto_symbols(bus_if.ed_auto_symbols), .scramble_on(bus_if.scramble_on),
		.cs_cca_allowed(bus_if.cs_cca_allowed), .psdu_code_div(bus_if.psdu_code_div));
	// 200 MHz clock
	always #2.5 pclk = ~pclk;
	// ==========================================================
	// monitor: sampled mid access cycle so the read data registered at setup has settled
	always @(negedge pclk)
	begin
		if (psel && penable && pready && !pwrite)
		begin
			e_cur = exp_q.pop_front();
			m_cur = msk_q.pop_front();
			`CHK("apb read", e_cur & m_cur, {pslverr, buffer_protected, demod_enable, prdata} & m_cur)
		end
	end
	// ==========================================================
	// apb master; request held until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// read with a note {error, protected, demod, data}; cm selects the side flags to judge
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [2:0] c, input logic [2:0] cm);
		exp_q.push_back({c, e});
		msk_q.push_back({cm, (cm[2] & c[2]) ? 32'h0 : 32'hffffffff});
		apb(1'b0, a, 32'h0);
	endtask : rd
	task st(input logic [4:0] s, input logic [1:0] pd);
		rd(rpmrx_pkg::A_STATUS, {27'h0, s}, {1'b0, pd}, 3'b111);
	endtask : st
	// command plus one spare cycle so the device has taken the strobe
	task cmd(input logic [4:0] c);
		apb(1'b1, rpmrx_pkg::A_CMD, {27'h0, c});
		@(posedge pclk);
	endtask : cmd
	task peer(input logic s, input logic d, input logic [7:0] r, input logic f);
		@(posedge pclk);
		sfd_found  <= s;
		frame_done <= d;
		frame_rssi <= r;
		fcs_ok     <= f;
		@(posedge pclk);
		sfd_found  <= 1'b0;
		frame_done <= 1'b0;
	endtask : peer
	task frame(input logic [7:0] r, input logic f);
		peer(1'b1, 1'b0, r, 1'b0);
		st(rpmrx_pkg::ST_BUSY, 2'b01);
		peer(1'b0, 1'b1, r, f);
	endtask : frame
	// expected timing word from the mode bits
	function automatic logic [31:0] tword(input logic [7:0] p, input logic e);
		logic hr;
		hr = p[3] && (p[1:0] != 2'h0);
		return {hr, !hr, 3'h0, !hr ? 3'h1 : (p[1:0] == 2'h2 ? 3'h4 : 3'h2), hr ? 4'h2 : 4'h8,
			(hr && e) ? (p[2] ? 4'h3 : 4'h2) : 4'hc,
			p[3] ? (p[2] ? 16'h0c80 : 16'h1f40) : (p[2] ? 16'h1388 : 16'h2710)};
	endfunction : tword
	task summarize;
		if (err_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize
	// watchdog, far beyond the few hundred cycles of the sequence
	initial
	begin
		#200000;
		err_count++;
		summarize();
	end
	// ==========================================================
	// main sequence
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{sfd_found, frame_done, fcs_ok, frame_rssi} = '0;
		err_count = 0;
		checks_done = 0;
		seed = 32'hb879;
		frame_lqi = 8'($random(seed));
		frame_ed = 8'($random(seed));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(rpmrx_pkg::A_PHY_CTRL, 32'h20, 3'b0, 3'b100);
		rd(rpmrx_pkg::A_SYNC, 32'h0, 3'b0, 3'b100);
		rd(rpmrx_pkg::A_EXT, 32'h0, 3'b0, 3'b100);
		rd(rpmrx_pkg::A_RELEASE, 32'h1, 3'b0, 3'b100);
		st(rpmrx_pkg::ST_OFF, 2'b00);
		// every family, sub mode and rate, random scrambler, spectrum and ack bits
		for (int i = 0; i < 16; i++)
		begin
			phy = {2'b00, 1'($random(seed)), 1'($random(seed)), i[0], i[1], i[0] ? 2'(i / 4) : 2'b00};
			ackb = 1'($random(seed));
			apb(1'b1, rpmrx_pkg::A_PHY_CTRL, {24'h0, phy});
			apb(1'b1, rpmrx_pkg::A_EXT, {29'h0, ackb, 2'b00});
			rd(rpmrx_pkg::A_PHY_CTRL, {24'h0, phy}, 3'b0, 3'b100);
			rd(rpmrx_pkg::A_TIMING, tword(phy, ackb), 3'b0, 3'b100);
		end
		// listening, threshold, refused mode change, detector disable
		apb(1'b1, rpmrx_pkg::A_SYNC, 32'h40);
		apb(1'b1, rpmrx_pkg::A_PHY_CTRL, 32'h28);
		cmd(rpmrx_pkg::CMD_RX_ON);
		st(rpmrx_pkg::ST_RX, 2'b00);
		apb(1'b1, rpmrx_pkg::A_PHY_CTRL, 32'h0a);
		rd(rpmrx_pkg::A_PHY_CTRL, 32'h28, 3'b0, 3'b100);
		peer(1'b1, 1'b0, 8'h3f, 1'b0);
		st(rpmrx_pkg::ST_RX, 2'b00);
		frame(8'h40, 1'b1);
		st(rpmrx_pkg::ST_RX, 2'b00);
		rd(rpmrx_pkg::A_RXINFO, {7'h0, 1'b1, frame_lqi, frame_ed, 7'h0, 1'b1}, 3'b0, 3'b100);
		apb(1'b1, rpmrx_pkg::A_SYNC, 32'hc0);
		peer(1'b1, 1'b0, 8'h50, 1'b0);
		st(rpmrx_pkg::ST_RX, 2'b00);
		apb(1'b1, rpmrx_pkg::A_SYNC, 32'h40);
		// safe receive: only a good frame is held until the host releases it
		cmd(rpmrx_pkg::CMD_TRANSCEIVER_OFF_STATE);
		apb(1'b1, rpmrx_pkg::A_PHY_CTRL, 32'ha8);
		cmd(rpmrx_pkg::CMD_RX_ON);
		frame(8'h50, 1'b0);
		st(rpmrx_pkg::ST_RX, 2'b00);
		frame(8'h50, 1'b1);
		st(rpmrx_pkg::ST_RX, 2'b10);
		peer(1'b1, 1'b0, 8'h50, 1'b0);
		st(rpmrx_pkg::ST_RX, 2'b10);
		apb(1'b1, rpmrx_pkg::A_RELEASE, 32'h0);
		apb(1'b1, rpmrx_pkg::A_RELEASE, 32'h1);
		st(rpmrx_pkg::ST_RX, 2'b00);
		// auto ack listen starts only from pll
		cmd(rpmrx_pkg::CMD_TRANSCEIVER_OFF_STATE);
		cmd(rpmrx_pkg::CMD_AACK_ON);
		st(rpmrx_pkg::ST_OFF, 2'b00);
		cmd(rpmrx_pkg::CMD_PLL_ON);
		cmd(rpmrx_pkg::CMD_AACK_ON);
		st(rpmrx_pkg::ST_AACK, 2'b00);
		cmd(rpmrx_pkg::CMD_TRANSCEIVER_OFF_STATE);
		cmd(rpmrx_pkg::CMD_PLL_ON);
		cmd(rpmrx_pkg::CMD_RX_ON);
		st(rpmrx_pkg::ST_RX, 2'b00);
		// high rate frame: link quality hidden from the host
		cmd(rpmrx_pkg::CMD_TRANSCEIVER_OFF_STATE);
		apb(1'b1, rpmrx_pkg::A_PHY_CTRL, 32'h29);
		cmd(rpmrx_pkg::CMD_RX_ON);
		frame(8'h50, 1'b1);
		rd(rpmrx_pkg::A_RXINFO, {7'h0, 1'b1, 8'h00, frame_ed, 7'h0, 1'b1}, 3'b0, 3'b100);
		// unmapped and unaligned places
		rd(8'h20, 32'h0, 3'b100, 3'b100);
		rd(8'h02, 32'h0, 3'b100, 3'b100);
		repeat (4) @(posedge pclk);
		if (exp_q.size() != 0)
			err_count++;
		summarize();
	end
endmodule : test_radio_phy_mode_rx_control
`default_nettype wire
